// ### hdl/flash_command_controller.sv
module flash_command_controller
    import flash_cmd_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          rst_n_in,
    input  wire wb_req_t       wb_req_in,
    input  wire config_field_t config_field_in,
    input  wire logic [1:0]    array_err_in,
    output logic               wb_ack_out,
    output logic [31:0]        wb_dat_out,
    output logic               irq_out,
    output logic               busy_out
);
    typedef struct packed {
        logic              ack;
        logic [7:0]        rdata;
        logic              irq;
        seq_state_t        fsm;
        clkdiv_t           clkdiv;
        logic [2:0]        idx;
        logic              ccie;
        status_t           stat;
        pflash_prot_t      pflash_protect_register;
        eeprom_prot_t      eeprom_protect_register;
        logic [7:0]        option;
        logic [7:0]        security;
        logic [63:0]       key;
        logic              key_failed;
        logic [15:0]       timer;
        logic [5:0][15:0]  obj;
    } ctl_state_t;

    ctl_state_t s_ff;
    ctl_state_t nxt_s;
    logic       tick;

    // ------------------------------------------------------------
    // protection decode
    // ------------------------------------------------------------
    function automatic logic eeprom_hit(input logic [17:0] a, input eeprom_prot_t p);
        logic [4:0]  code;
        logic [17:0] top;
        code = (p.size > EE_MAX_CODE) ? EE_MAX_CODE : p.size;
        top  = EE_BASE + 18'(({13'h0, code} + 18'h1) * EE_STEP);
        return p.en && (a >= EE_BASE) && (a < top);
    endfunction

    function automatic logic pflash_hit(input logic [17:0] a, input pflash_prot_t p);
        logic [17:0] low_end;
        logic [17:0] high_start;
        logic        in_low;
        logic        in_high;
        low_end    = PF_LOW_BASE + 18'(PF_LOW_UNIT << p.low_size);
        high_start = PF_HIGH_TOP - 18'(PF_HIGH_UNIT << p.high_size) + 18'h1;
        in_low     = p.low_en && (a >= PF_LOW_BASE) && (a < low_end);
        in_high    = p.high_en && (a >= high_start);
        return (a >= PF_BASE) && (in_low || in_high || (p.other_en && !in_low && !in_high));
    endfunction

    flash_timebase i_flash_timebase (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (s_ff.fsm == S_RUN),
        .divider_in (s_ff.clkdiv.value),
        .tick_out   (tick)
    );

    logic        req;
    logic        wr;
    logic [3:0]  ridx;
    logic        mapped;
    logic [7:0]  wd;
    logic [7:0]  rv;
    logic [7:0]  cmd;
    logic [17:0] addr;
    logic        legal;
    logic [2:0]  need_idx;
    logic        is_ee;
    logic        is_key;

    always_comb begin
        nxt_s    = s_ff;
        req      = wb_req_in.cyc && wb_req_in.stb;
        ridx     = wb_req_in.adr[5:2];
        mapped   = (wb_req_in.adr[7:6] == 2'h0) && (wb_req_in.adr[1:0] == 2'h0);
        wd       = wb_req_in.dat[7:0];
        wr       = req && s_ff.ack && wb_req_in.we && wb_req_in.sel[0] && mapped;
        cmd      = s_ff.obj[0][15:8];
        addr     = {s_ff.obj[0][1:0], s_ff.obj[1]};
        legal    = 1'b1;
        need_idx = IDX_ERASE;
        is_ee    = 1'b0;
        is_key   = 1'b0;

        // --------------------------------------------------------
        // bus slave: ack one cycle after the request, write at ack
        // --------------------------------------------------------
        nxt_s.ack = req && !s_ff.ack;
        rv        = 8'h00;
        if (mapped) begin
            case (ridx)
                REG_CLKDIV: rv = s_ff.clkdiv;
                REG_SEC:    rv = s_ff.security;
                REG_IDX:    rv = {5'h00, s_ff.idx};
                REG_OPT:    rv = s_ff.option;
                REG_CFG:    rv = {s_ff.ccie, 7'h00};
                REG_STAT:   rv = s_ff.stat;
                REG_PFLASH_PROTECT_REGISTER:  rv = s_ff.pflash_protect_register;
                REG_EEPROM_PROTECT_REGISTER: rv = s_ff.eeprom_protect_register;
                REG_OBJ_HI: rv = (s_ff.idx < OBJ_WORDS && s_ff.stat.command_complete_flag) ? s_ff.obj[s_ff.idx][15:8] : 8'h00;
                REG_OBJ_LO: rv = (s_ff.idx < OBJ_WORDS && s_ff.stat.command_complete_flag) ? s_ff.obj[s_ff.idx][7:0] : 8'h00;
                default:    rv = 8'h00;
            endcase
        end
        if (req && !s_ff.ack) begin
            nxt_s.rdata = rv;
        end

        if (wr) begin
            case (ridx)
                REG_CLKDIV: begin
                    nxt_s.clkdiv.loaded = 1'b1;
                    if (!s_ff.clkdiv.locked) begin
                        nxt_s.clkdiv.value  = wd[5:0];
                        nxt_s.clkdiv.locked = wd[DIV_LOCK_BIT];
                    end
                end
                REG_IDX: nxt_s.idx  = wd[2:0];
                REG_CFG: nxt_s.ccie = wd[CFG_CCIE_BIT];
                REG_STAT: begin
                    if (wd[STAT_ACCESS_ERROR_FLAG]) nxt_s.stat.access_error_flag = 1'b0;
                    if (wd[STAT_PROTECT_VIOLATION_FLAG]) nxt_s.stat.protect_violation_flag = 1'b0;
                    // flags as they stood before this write decide the launch
                    if (wd[STAT_COMMAND_COMPLETE_FLAG] && s_ff.stat.command_complete_flag && !s_ff.stat.access_error_flag && !s_ff.stat.protect_violation_flag
                        && s_ff.fsm == S_IDLE) begin
                        nxt_s.stat.command_complete_flag   = 1'b0;
                        nxt_s.stat.completion_status = 2'h0;
                        nxt_s.fsm         = S_CHECK;
                    end
                end
                REG_OBJ_HI, REG_OBJ_LO: begin
                    if (!s_ff.stat.command_complete_flag) begin
                        nxt_s.stat.access_error_flag = 1'b1;
                    end else if (!s_ff.stat.protect_violation_flag && s_ff.idx < OBJ_WORDS) begin
                        if (ridx == REG_OBJ_HI) begin
                            nxt_s.obj[s_ff.idx][15:8] = wd;
                        end else begin
                            nxt_s.obj[s_ff.idx][7:0] = wd;
                        end
                    end
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------
        // command sequencer; its flag sets land after bus clears
        // --------------------------------------------------------
        case (s_ff.fsm)
            S_LOAD: begin
                // protection and security come from the configuration field
                nxt_s.pflash_protect_register    = config_field_in.pflash_prot;
                nxt_s.eeprom_protect_register   = config_field_in.eeprom_prot;
                nxt_s.option   = config_field_in.option;
                nxt_s.security = config_field_in.security;
                nxt_s.key      = config_field_in.key;
                nxt_s.stat.command_complete_flag = 1'b1;
                nxt_s.fsm      = S_IDLE;
            end
            S_IDLE: ;
            S_CHECK: begin
                case (cmd)
                    CMD_PROG_PF:    need_idx = IDX_PROG;
                    CMD_ERASE_PF:   need_idx = IDX_ERASE;
                    CMD_PROG_EE: begin
                        need_idx = IDX_PROG;
                        is_ee    = 1'b1;
                    end
                    CMD_ERASE_EE: begin
                        need_idx = IDX_ERASE;
                        is_ee    = 1'b1;
                    end
                    CMD_VERIFY_KEY: begin
                        need_idx = IDX_KEY;
                        is_key   = 1'b1;
                    end
                    default: legal = 1'b0;
                endcase
                if (!legal || s_ff.idx != need_idx || !s_ff.clkdiv.loaded
                    || (is_key && s_ff.key_failed)) begin
                    nxt_s.stat.access_error_flag = 1'b1;
                    nxt_s.stat.command_complete_flag   = 1'b1;
                    nxt_s.fsm         = S_IDLE;
                end else if (is_key) begin
                    // a wrong key disables further attempts until reset
                    if ({s_ff.obj[1], s_ff.obj[2], s_ff.obj[3], s_ff.obj[4]} == s_ff.key) begin
                        nxt_s.security = SEC_UNSECURE;
                    end else begin
                        nxt_s.stat.access_error_flag = 1'b1;
                        nxt_s.key_failed  = 1'b1;
                    end
                    nxt_s.stat.command_complete_flag = 1'b1;
                    nxt_s.fsm       = S_IDLE;
                end else if (is_ee ? eeprom_hit(addr, s_ff.eeprom_protect_register) : pflash_hit(addr, s_ff.pflash_protect_register)) begin
                    nxt_s.stat.protect_violation_flag = 1'b1;
                    nxt_s.stat.command_complete_flag   = 1'b1;
                    nxt_s.fsm         = S_IDLE;
                end else begin
                    nxt_s.stat.busy = 1'b1;
                    nxt_s.timer     = OP_TICKS;
                    nxt_s.fsm       = S_RUN;
                end
            end
            S_RUN: begin
                if (tick) begin
                    if (s_ff.timer <= 16'h0001) begin
                        nxt_s.stat.completion_status = array_err_in;
                        nxt_s.stat.busy   = 1'b0;
                        nxt_s.stat.command_complete_flag   = 1'b1;
                        nxt_s.timer       = 16'h0000;
                        nxt_s.fsm         = S_IDLE;
                    end else begin
                        nxt_s.timer = s_ff.timer - 16'h0001;
                    end
                end
            end
            default: nxt_s.fsm = S_IDLE;
        endcase

        nxt_s.stat.rsvd6 = 1'b0;
        nxt_s.stat.rsvd2 = 1'b0;
        nxt_s.irq        = nxt_s.stat.command_complete_flag && nxt_s.ccie;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_ff     <= '0;
            s_ff.fsm <= S_LOAD;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_ack_out = s_ff.ack;
    assign wb_dat_out = {24'h000000, s_ff.rdata};
    assign irq_out    = s_ff.irq;
    assign busy_out   = s_ff.stat.busy;
endmodule

// ### inc/flash_cmd_pkg.sv
package flash_cmd_pkg;
    // ------------------------------------------------------------
    // register word indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CLKDIV = 4'h0;
    localparam logic [3:0] REG_SEC    = 4'h1;
    localparam logic [3:0] REG_IDX    = 4'h2;
    localparam logic [3:0] REG_OPT    = 4'h3;
    localparam logic [3:0] REG_CFG    = 4'h4;
    localparam logic [3:0] REG_STAT   = 4'h6;
    localparam logic [3:0] REG_PFLASH_PROTECT_REGISTER  = 4'h8;
    localparam logic [3:0] REG_EEPROM_PROTECT_REGISTER = 4'h9;
    localparam logic [3:0] REG_OBJ_HI = 4'ha;
    localparam logic [3:0] REG_OBJ_LO = 4'hb;

    // ------------------------------------------------------------
    // field positions, object word count and unsecure value
    // ------------------------------------------------------------
    localparam int         STAT_COMMAND_COMPLETE_FLAG    = 7;
    localparam int         STAT_ACCESS_ERROR_FLAG  = 5;
    localparam int         STAT_PROTECT_VIOLATION_FLAG  = 4;
    localparam int         DIV_LOCK_BIT = 6;
    localparam int         CFG_CCIE_BIT = 7;
    localparam logic [2:0] OBJ_WORDS    = 3'h6;
    localparam logic [7:0] SEC_UNSECURE = 8'h02;

    // ------------------------------------------------------------
    // commands and the last object index each needs
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_PROG_PF   = 8'h06;
    localparam logic [7:0] CMD_ERASE_PF  = 8'h0a;
    localparam logic [7:0] CMD_VERIFY_KEY = 8'h0c;
    localparam logic [7:0] CMD_PROG_EE   = 8'h11;
    localparam logic [7:0] CMD_ERASE_EE  = 8'h12;
    localparam logic [2:0] IDX_PROG      = 3'h2;
    localparam logic [2:0] IDX_ERASE     = 3'h1;
    localparam logic [2:0] IDX_KEY       = 3'h4;

    // ------------------------------------------------------------
    // memory map of the protected arrays and configuration field
    // ------------------------------------------------------------
    localparam logic [17:0] EE_BASE      = 18'h00400;
    localparam logic [17:0] EE_STEP      = 18'h00020;
    localparam logic [4:0]  EE_MAX_CODE  = 5'h0f;
    localparam logic [17:0] PF_BASE      = 18'h34000;
    localparam logic [17:0] PF_LOW_BASE  = 18'h38000;
    localparam logic [17:0] PF_HIGH_TOP  = 18'h3ffff;
    localparam logic [17:0] PF_LOW_UNIT  = 18'h00400;
    localparam logic [17:0] PF_HIGH_UNIT = 18'h00800;
    localparam logic [17:0] CFG_KEY_ADDR = 18'h3ff00;
    localparam logic [17:0] CFG_RSV_ADDR = 18'h3ff08;
    localparam logic [17:0] CFG_PFLASH_PROTECT_REGISTER_ADDR  = 18'h3ff0c;
    localparam logic [17:0] CFG_EEPROM_PROTECT_REGISTER_ADDR = 18'h3ff0d;
    localparam logic [17:0] CFG_OPT_ADDR    = 18'h3ff0e;
    localparam logic [17:0] CFG_SEC_ADDR    = 18'h3ff0f;

    // ------------------------------------------------------------
    // timing: the timebase ticks once per microsecond
    // ------------------------------------------------------------
    localparam int          OP_TIME_US   = 20;
    localparam int          TICK_MHZ     = 1;
    localparam logic [15:0] OP_TICKS     = 16'(OP_TIME_US * TICK_MHZ);

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic [63:0] key;
        logic [31:0] reserved;
        logic [7:0]  pflash_prot;
        logic [7:0]  eeprom_prot;
        logic [7:0]  option;
        logic [7:0]  security;
    } config_field_t;

    typedef struct packed {
        logic       command_complete_flag;
        logic       rsvd6;
        logic       access_error_flag;
        logic       protect_violation_flag;
        logic       busy;
        logic       rsvd2;
        logic [1:0] completion_status;
    } status_t;

    typedef struct packed {
        logic       loaded;
        logic       locked;
        logic [5:0] value;
    } clkdiv_t;

    typedef struct packed {
        logic       other_en;
        logic       high_en;
        logic [1:0] high_size;
        logic       low_en;
        logic [1:0] low_size;
        logic       rsvd;
    } pflash_prot_t;

    typedef struct packed {
        logic       en;
        logic [1:0] rsvd;
        logic [4:0] size;
    } eeprom_prot_t;

    typedef enum logic [3:0] {
        S_LOAD  = 4'h1,
        S_IDLE  = 4'h2,
        S_CHECK = 4'h4,
        S_RUN   = 4'h8
    } seq_state_t;
endpackage

// ### hdl/flash_timebase.sv
module flash_timebase
    import flash_cmd_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic [5:0] divider_in,
    output logic            tick_out
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } tb_state_t;

    tb_state_t s_ff;
    tb_state_t nxt_s;

    // ------------------------------------------------------------
    // divide by value + 1 down to roughly 1 MHz
    // ------------------------------------------------------------
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.tick = 1'b0;
        if (!enable_in) begin
            nxt_s.cnt = 6'h00;
        end else if (s_ff.cnt >= divider_in) begin
            nxt_s.cnt  = 6'h00;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick_out = s_ff.tick;
endmodule

// ### verification/flash_command_controller_chk.sv
module flash_command_controller_chk
    import flash_cmd_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          rst_n_in,
    input wire wb_req_t       wb_req_in,
    input wire config_field_t config_field_in,
    input wire logic [1:0]    array_err_in,
    input wire logic          wb_ack_out,
    input wire logic [31:0]   wb_dat_out,
    input wire logic          irq_out,
    input wire logic          busy_out
);
    localparam logic [7:0] A_DIV  = {2'b00, REG_CLKDIV, 2'b00};
    localparam logic [7:0] A_IDX  = {2'b00, REG_IDX, 2'b00};
    localparam logic [7:0] A_STAT = {2'b00, REG_STAT, 2'b00};
    localparam logic [7:0] A_HI   = {2'b00, REG_OBJ_HI, 2'b00};
    localparam logic [7:0] A_LO   = {2'b00, REG_OBJ_LO, 2'b00};

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic        req;
    logic        rd_ack;
    logic        wr_ack;
    logic [7:0]  adr;
    logic        div_wr_ff;
    logic [2:0]  idx_ff;
    logic [15:0] busy_cnt_ff;
    assign req    = wb_req_in.cyc && wb_req_in.stb;
    assign adr    = wb_req_in.adr;
    assign rd_ack = wb_ack_out && req && !wb_req_in.we;
    assign wr_ack = wb_ack_out && req && wb_req_in.we && wb_req_in.sel[0];

    // shadow of what software wrote, plus a count of busy cycles, so reads can be judged without the body
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_wr_ff   <= 1'b0;
            idx_ff      <= 3'h0;
            busy_cnt_ff <= 16'h0;
        end else begin
            if (wr_ack && adr == A_DIV) div_wr_ff <= 1'b1;
            if (wr_ack && adr == A_IDX) idx_ff <= wb_req_in.dat[2:0];
            busy_cnt_ff <= busy_out ? busy_cnt_ff + 16'h1 : 16'h0;
        end
    end

    chk_ack_follows: assert property (req && !wb_ack_out |=> wb_ack_out) else $error("ack late");
    chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    chk_ack_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
    chk_dat_upper: assert property (rd_ack |-> wb_dat_out[31:8] == 24'h0) else $error("upper data set");
    chk_stat_rsvd: assert property (rd_ack && adr == A_STAT |-> !wb_dat_out[2]) else $error("bit2 set");
    chk_busy_excl: assert property (rd_ack && adr == A_STAT |-> !(wb_dat_out[7] && wb_dat_out[3]))
        else $error("busy with complete");
    chk_busy_mirror: assert property (rd_ack && adr == A_STAT |-> wb_dat_out[3] == $past(busy_out))
        else $error("busy pin differs");
    chk_busy_bound: assert property (busy_cnt_ff <= 16'd1300) else $error("operation too long");
    chk_div_loaded: assert property (rd_ack && adr == A_DIV |-> wb_dat_out[7] == div_wr_ff)
        else $error("loaded bit wrong");
    chk_obj_unimpl: assert property (rd_ack && (adr == A_HI || adr == A_LO) && idx_ff[2:1] == 2'b11
        |-> wb_dat_out[7:0] == 8'h00) else $error("unimplemented word nonzero");
    chk_irq_idle: assert property (irq_out |-> !busy_out) else $error("irq while busy");
endmodule

bind flash_command_controller flash_command_controller_chk i_flash_command_controller_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_req_in(wb_req_in), .config_field_in(config_field_in),
    .array_err_in(array_err_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .irq_out(irq_out), .busy_out(busy_out));

// ### verification/flash_array_model.sv
module flash_array_model
    import flash_cmd_pkg::*;
#(
    parameter logic [63:0] KEY = 64'h5a3c_69a5_c3e1_1e87 // arbitrary value
)
(
    input  wire logic [1:0] err_sel_in,
    input  wire logic       busy_in,
    output config_field_t   config_field_out,
    output logic [1:0]      array_err_out
);
    assign config_field_out.key         = KEY;
    assign config_field_out.reserved    = 32'hffff_ffff;
    assign config_field_out.pflash_prot = 8'h40;
    assign config_field_out.eeprom_prot = 8'h80;
    assign config_field_out.option      = 8'h00;
    assign config_field_out.security    = 8'h01;
    // outside an operation the status is stale, so show its inverse
    assign array_err_out = busy_in ? err_sel_in : ~err_sel_in;
endmodule

// ### verification/test_flash_command_controller.sv
module test_flash_command_controller
    import flash_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] m;
        logic [7:0] v;
    } note_t;
    typedef struct packed {
        logic [7:0]  c;
        logic [2:0]  l;
        logic [17:0] a;
        logic [7:0]  e;
    } op_t;

    logic          clk_in;
    logic          rst_n_in;
    wb_req_t       req;
    config_field_t cfg;
    logic [1:0]    err_sel;
    logic [1:0]    aerr;
    logic          ack;
    logic [31:0]   dat;
    logic          irq;
    logic          busy;
    int            error_cnt;
    int            checks;
    note_t         notes[$];
    logic [5:0]    v;
    logic [7:0]    d;
    op_t           ops[5] = '{{CMD_ERASE_EE, IDX_ERASE, 18'h0041f, 8'h90}, {CMD_PROG_EE, IDX_PROG, 18'h00420, 8'h80},
                              {CMD_ERASE_PF, IDX_ERASE, 18'h3f800, 8'h90}, {CMD_PROG_PF, IDX_PROG, 18'h3f7f8, 8'h80},
                              {8'h55, IDX_ERASE, 18'h00420, 8'ha0}};

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    flash_array_model i_flash_array_model (.err_sel_in(err_sel), .busy_in(busy), .config_field_out(cfg),
        .array_err_out(aerr));
    flash_command_controller i_flash_command_controller (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_req_in(req),
        .config_field_in(cfg), .array_err_in(aerr), .wb_ack_out(ack), .wb_dat_out(dat), .irq_out(irq),
        .busy_out(busy));

    // ------------------------------------------------------------
    // comparison and bus tasks
    // ------------------------------------------------------------
    task automatic cmp8(input logic [7:0] got, input note_t n);
        checks++;
        if ((got & n.m) !== (n.v & n.m)) begin
            error_cnt++;
            $display("MISMATCH t=%0t read %h expected %h", $time, got, n.v);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    always @(posedge clk_in) begin
        if (ack === 1'b1 && req.we === 1'b0 && notes.size() > 0) cmp8(dat[7:0], notes.pop_front());
    end

    function automatic logic [7:0] ad(input logic [3:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q);
        int n = 0;
        @(posedge clk_in);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, wd}};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("MISMATCH t=%0t no acknowledge", $time);
        end
        q = dat[7:0];
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        logic [7:0] q;
        bus(1'b1, a, wd, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        logic [7:0] q;
        notes.push_back('{m: m, v: e});
        bus(1'b0, a, 8'h00, q);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [2:0] l, input logic [17:0] a, input logic [7:0] wd);
        wr(ad(REG_IDX), 8'h00);
        wr(ad(REG_OBJ_HI), c);
        wr(ad(REG_OBJ_LO), {6'h00, a[17:16]});
        wr(ad(REG_IDX), 8'h01);
        wr(ad(REG_OBJ_HI), a[15:8]);
        wr(ad(REG_OBJ_LO), a[7:0]);
        wr(ad(REG_IDX), 8'h02);
        wr(ad(REG_OBJ_HI), wd);
        wr(ad(REG_OBJ_LO), ~wd);
        wr(ad(REG_IDX), {5'h00, l});
        wr(ad(REG_STAT), 8'h80);
    endtask
    task automatic wait_done();
        logic [7:0] q = 8'h00;
        int n = 0;
        do begin
            notes.push_back('{m: 8'h00, v: 8'h00});
            bus(1'b0, ad(REG_STAT), 8'h00, q);
            n++;
        end while (q[7] !== 1'b1 && n < 500);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        req = '0;
        err_sel = 2'b00;
        rst_n_in = 1'b0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(95));
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(ad(REG_STAT), 8'h80);
        rd(ad(REG_CLKDIV), 8'h00);
        rd(ad(REG_PFLASH_PROTECT_REGISTER), cfg.pflash_prot);
        rd(ad(REG_EEPROM_PROTECT_REGISTER), cfg.eeprom_prot);
        rd(ad(REG_OPT), cfg.option);
        rd(ad(REG_SEC), cfg.security);
        rd(8'h14, 8'h00);
        rd(8'h19, 8'h00);
        rd(8'h58, 8'h00);
        $display("test reset_values done");
        cmd(CMD_ERASE_EE, IDX_ERASE, 18'h00420, 8'h00);
        wait_done();
        rd(ad(REG_STAT), 8'ha0, 8'hfc);
        wr(ad(REG_STAT), 8'h00);
        rd(ad(REG_STAT), 8'ha0, 8'hfc);
        wr(ad(REG_STAT), 8'h80);
        rd(ad(REG_STAT), 8'ha0, 8'hfc);
        cmp1(busy, 1'b0);
        wr(ad(REG_STAT), 8'h20);
        rd(ad(REG_STAT), 8'h80, 8'hfc);
        $display("test access_error done");
        v = 6'($urandom % 4);
        wr(ad(REG_CLKDIV), {2'b00, v});
        rd(ad(REG_CLKDIV), {2'b10, v});
        for (int i = 0; i < 5; i++) begin
            err_sel <= 2'($urandom);
            cmd(ops[i].c, ops[i].l, ops[i].a, 8'($urandom));
            wait_done();
            rd(ad(REG_STAT), ops[i].e | ((ops[i].e == 8'h80) ? {6'h00, err_sel} : 8'h00),
               (ops[i].e == 8'h80) ? 8'hff : 8'hfc);
            wr(ad(REG_STAT), 8'h30);
        end
        $display("test command_table done");
        d = 8'($urandom);
        err_sel <= 2'b00;
        cmd(CMD_PROG_EE, IDX_PROG, 18'h00420, d);
        for (int n = 0; n < 10 && busy !== 1'b1; n++) @(posedge clk_in);
        cmp1(busy, 1'b1);
        rd(ad(REG_STAT), 8'h08, 8'hfc);
        rd(ad(REG_OBJ_HI), 8'h00);
        wr(ad(REG_OBJ_HI), ~d);
        wait_done();
        rd(ad(REG_STAT), 8'ha0, 8'hfc);
        rd(ad(REG_OBJ_HI), d);
        rd(ad(REG_OBJ_LO), ~d);
        wr(ad(REG_STAT), 8'h30);
        $display("test object_lock done");
        for (int k = 6; k < 8; k++) begin
            wr(ad(REG_IDX), 8'(k));
            wr(ad(REG_OBJ_HI), 8'hab);
            wr(ad(REG_OBJ_LO), 8'hcd);
            rd(ad(REG_OBJ_HI), 8'h00);
            rd(ad(REG_OBJ_LO), 8'h00);
        end
        wr(ad(REG_CFG), 8'h80);
        repeat (2) @(posedge clk_in);
        cmp1(irq, 1'b1);
        wr(ad(REG_CFG), 8'h00);
        repeat (2) @(posedge clk_in);
        cmp1(irq, 1'b0);
        $display("test index_and_irq done");
        wr(ad(REG_CLKDIV), {2'b01, v});
        rd(ad(REG_CLKDIV), {2'b11, v});
        wr(ad(REG_CLKDIV), {2'b00, ~v});
        rd(ad(REG_CLKDIV), {2'b11, v});
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(ad(REG_CLKDIV), 8'h00);
        rd(ad(REG_STAT), 8'h80);
        $display("test divider_lock done");
        results();
    end
endmodule
